// File: hw/port5_pkg.sv
package port5_pkg;
	localparam int PORT_WIDTH = 7;
	localparam int FUNC_PINS = 4;
	localparam int ADDR_WIDTH = 20;
	// printed offsets are not all multiples of four: index, byte address x4
	localparam logic [19:0] IDX_OUTPUT_DATA = 20'h03F15;
	localparam logic [19:0] IDX_PIN_LEVELS = 20'h03F25;
	localparam logic [19:0] IDX_OUTPUT_FUNCTION_SELECT = 20'h03F2C;
	localparam logic [19:0] IDX_DIRECTION = 20'h03F35;
	localparam logic [19:0] IDX_PULLUP_ENABLE = 20'h03F45;
	localparam logic [19:0] IDX_NOISE_FILTER_CONTROL = 20'h03F50;
	localparam int NF_ZERO_CROSS0_BIT = 3;
	localparam int NF_ZERO_CROSS1_BIT = 7;
	localparam int ZC0_PIN = 4;
	localparam int ZC1_PIN = 5;
	localparam int LARGE_CURRENT_LSB = 4;
	localparam logic [6:0] RESET_DIRECTION = 7'h00;
	localparam logic [6:0] RESET_PULLUP = 7'h00;
	localparam logic [7:0] RESET_OUTPUT_FUNCTION = 8'h00;
	localparam logic [7:0] RESET_NOISE_FILTER = 8'h00;
	localparam logic [6:0] RESET_OUTPUT_DATA = 7'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [ADDR_WIDTH-1:0] byte_addr(
		input logic [19:0] idx
	);
		byte_addr = {idx[ADDR_WIDTH-3:0], 2'h0};
	endfunction
endpackage

// File: hw/port5_sync.sv
`timescale 1ns/1ns
module port5_sync import port5_pkg::*; #(
	parameter int WIDTH = 7
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage;

	// first stage feeds only the second stage
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage <= '0;
			sync_out <= '0;
		end else begin
			stage <= async_in;
			sync_out <= stage;
		end
	end
endmodule // port5_sync

// File: hw/port5_pin_mux.sv
`timescale 1ns/1ns
module port5_pin_mux import port5_pkg::*; (
	input wire logic [PORT_WIDTH-1:0] port_output_data_in,
	input wire logic [PORT_WIDTH-1:0] port_direction_in,
	input wire logic [7:0] port_output_function_select_in,
	input wire logic [FUNC_PINS-1:0] timer_out_in,
	output logic [PORT_WIDTH-1:0] next_pin_out,
	output logic [PORT_WIDTH-1:0] next_pin_oe,
	output logic [FUNC_PINS-1:0] next_large_current
);
	always_comb begin
		next_pin_out = port_output_data_in;
		next_pin_oe = port_direction_in;
		next_large_current = '0;
		for (int i = 0; i < FUNC_PINS; i++) begin
			if (port_output_function_select_in[i]) begin
				next_pin_out[i] = timer_out_in[i];
			end
			// large current applies to either source of the pin
			next_large_current[i] = port_direction_in[i] &
				port_output_function_select_in[LARGE_CURRENT_LSB + i];
			if (next_large_current[i]) begin
				// open N-channel: pull low for 0, release for 1
				next_pin_oe[i] = ~next_pin_out[i];
				next_pin_out[i] = 1'b0;
			end
		end
	end
endmodule // port5_pin_mux

// File: hw/port5_gpio.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Summary of operation
// - each of seven pins has a direction bit: 1 output, 0 input
// - output pin in general use drives the output data bit
// - input register read returns current pin levels
// - per-pin pull-up enable bit: 1 connects pull-up
// - pins 0-3 function select: 1 timer output, 0 port data
// - pin 0 carries timer 0 output when select bit 0 set
// - pin 1 carries timer 7 output when select bit 1 set
// - pin 2 carries timer 2 output when select bit 2 set
// - pin 3 carries timer 8 output when select bit 3 set
// - pins 4-6 also feed external interrupt inputs
// - noise filter bit 3 puts zero-cross 0 on pin 4 input bit
// - noise filter bit 7 puts zero-cross 1 on pin 5 input bit
// - mode bits 4-7 give large-current open N-channel drive on pins 0-3
// - large current combines with timer or port data source
// - bit 7 of data, input, direction, pull-up not implemented
module port5_gpio import port5_pkg::*; (
	// clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RESET_N_IN,
	// axi4-lite write address and data
	input wire logic [ADDR_WIDTH-1:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	// axi4-lite write response
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	// axi4-lite read
	input wire logic [ADDR_WIDTH-1:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	// pins
	input wire logic [PORT_WIDTH-1:0] PIN_IN,
	output logic [PORT_WIDTH-1:0] PIN_OUT,
	output logic [PORT_WIDTH-1:0] PIN_OE_OUT,
	output logic [PORT_WIDTH-1:0] PULLUP_EN_OUT,
	output logic [FUNC_PINS-1:0] LARGE_CURRENT_OUT,
	// peripherals
	input wire logic TIMER_ZERO_OUTPUT_IN,
	input wire logic TIMER_SEVEN_OUTPUT_IN,
	input wire logic TIMER_TWO_OUTPUT_IN,
	input wire logic TIMER_EIGHT_OUTPUT_IN,
	input wire logic ZERO_CROSS0_IN,
	input wire logic ZERO_CROSS1_IN,
	output logic [2:0] EXT_INTERRUPT_OUT,
	output logic [7:0] NOISE_FILTER_CONTROL_OUT
);
	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_COLLECT = 3'b010,
		WR_RESP = 3'b100
	} wr_state_t;

	logic [PORT_WIDTH-1:0] port_output_data;
	logic [PORT_WIDTH-1:0] port_direction;
	logic [PORT_WIDTH-1:0] port_pullup_enable;
	logic [7:0] port_output_function_select;
	logic [7:0] noise_filter_control;
	logic [PORT_WIDTH-1:0] pin_sync;
	logic [1:0] zc_sync;
	logic [PORT_WIDTH-1:0] port_pin_levels;
	logic [PORT_WIDTH-1:0] next_pin_out;
	logic [PORT_WIDTH-1:0] next_pin_oe;
	logic [FUNC_PINS-1:0] next_large_current;
	logic [FUNC_PINS-1:0] timer_out;
	wr_state_t wr_state;
	logic aw_held;
	logic w_held;
	logic [ADDR_WIDTH-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;

	port5_sync #(.WIDTH(PORT_WIDTH)) u_pin_sync (
		.clk_in(REF_CLK_IN),
		.reset_n_in(RESET_N_IN),
		.async_in(PIN_IN),
		.sync_out(pin_sync)
	);

	port5_sync #(.WIDTH(2)) u_zc_sync (
		.clk_in(REF_CLK_IN),
		.reset_n_in(RESET_N_IN),
		.async_in({ZERO_CROSS1_IN, ZERO_CROSS0_IN}),
		.sync_out(zc_sync)
	);

	assign timer_out = {TIMER_EIGHT_OUTPUT_IN, TIMER_TWO_OUTPUT_IN,
		TIMER_SEVEN_OUTPUT_IN, TIMER_ZERO_OUTPUT_IN};

	port5_pin_mux u_mux (
		.port_output_data_in(port_output_data),
		.port_direction_in(port_direction),
		.port_output_function_select_in(port_output_function_select),
		.timer_out_in(timer_out),
		.next_pin_out(next_pin_out),
		.next_pin_oe(next_pin_oe),
		.next_large_current(next_large_current)
	);

	always_comb begin
		port_pin_levels = pin_sync;
		if (noise_filter_control[NF_ZERO_CROSS0_BIT]) begin
			port_pin_levels[ZC0_PIN] = zc_sync[0];
		end
		if (noise_filter_control[NF_ZERO_CROSS1_BIT]) begin
			port_pin_levels[ZC1_PIN] = zc_sync[1];
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			PIN_OUT <= '0;
			PIN_OE_OUT <= '0;
			PULLUP_EN_OUT <= '0;
			LARGE_CURRENT_OUT <= '0;
			EXT_INTERRUPT_OUT <= '0;
			NOISE_FILTER_CONTROL_OUT <= RESET_NOISE_FILTER;
		end else begin
			PIN_OUT <= next_pin_out;
			PIN_OE_OUT <= next_pin_oe;
			PULLUP_EN_OUT <= port_pullup_enable;
			LARGE_CURRENT_OUT <= next_large_current;
			EXT_INTERRUPT_OUT <= pin_sync[6:4];
			NOISE_FILTER_CONTROL_OUT <= noise_filter_control;
		end
	end

	function automatic logic decode_ok(input logic [ADDR_WIDTH-1:0] a);
		decode_ok = (a == byte_addr(IDX_OUTPUT_DATA)) ||
			(a == byte_addr(IDX_PIN_LEVELS)) ||
			(a == byte_addr(IDX_OUTPUT_FUNCTION_SELECT)) ||
			(a == byte_addr(IDX_DIRECTION)) ||
			(a == byte_addr(IDX_PULLUP_ENABLE)) ||
			(a == byte_addr(IDX_NOISE_FILTER_CONTROL));
	endfunction

	// write channel: address and data in either order
	assign wr_fire = (wr_state == WR_COLLECT) && aw_held && w_held;

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			wr_state <= WR_IDLE;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			AWREADY_OUT <= 1'b0;
			WREADY_OUT <= 1'b0;
			BVALID_OUT <= 1'b0;
			BRESP_OUT <= RESP_OKAY;
		end else begin
			unique case (wr_state)
				WR_IDLE: begin
					AWREADY_OUT <= 1'b1;
					WREADY_OUT <= 1'b1;
					aw_held <= 1'b0;
					w_held <= 1'b0;
					wr_state <= WR_COLLECT;
				end
				WR_COLLECT: begin
					if (AWVALID_IN && AWREADY_OUT) begin
						aw_addr <= AWADDR_IN;
						aw_held <= 1'b1;
						AWREADY_OUT <= 1'b0;
					end
					if (WVALID_IN && WREADY_OUT) begin
						w_data <= WDATA_IN;
						w_strb <= WSTRB_IN;
						w_held <= 1'b1;
						WREADY_OUT <= 1'b0;
					end
					if (wr_fire) begin
						BVALID_OUT <= 1'b1;
						BRESP_OUT <= decode_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
						wr_state <= WR_RESP;
					end
				end
				WR_RESP: begin
					if (BREADY_IN) begin
						BVALID_OUT <= 1'b0;
						wr_state <= WR_IDLE;
					end
				end
				default: wr_state <= WR_IDLE;
			endcase
		end
	end

	// only byte lane 0 carries register bits; bit 7 of 7-bit regs dropped
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			port_output_data <= RESET_OUTPUT_DATA;
			port_direction <= RESET_DIRECTION;
			port_pullup_enable <= RESET_PULLUP;
			port_output_function_select <= RESET_OUTPUT_FUNCTION;
			noise_filter_control <= RESET_NOISE_FILTER;
		end else if (wr_fire && w_strb[0]) begin
			if (aw_addr == byte_addr(IDX_OUTPUT_DATA)) begin
				port_output_data <= w_data[6:0];
			end
			if (aw_addr == byte_addr(IDX_DIRECTION)) begin
				port_direction <= w_data[6:0];
			end
			if (aw_addr == byte_addr(IDX_PULLUP_ENABLE)) begin
				port_pullup_enable <= w_data[6:0];
			end
			if (aw_addr == byte_addr(IDX_OUTPUT_FUNCTION_SELECT)) begin
				port_output_function_select <= w_data[7:0];
			end
			if (aw_addr == byte_addr(IDX_NOISE_FILTER_CONTROL)) begin
				noise_filter_control <= w_data[7:0];
			end
			// pin level register has no write path
		end
	end

	// read channel: one read outstanding, answer the cycle after address
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT <= 1'b0;
			RDATA_OUT <= '0;
			RRESP_OUT <= RESP_OKAY;
		end else if (RVALID_OUT) begin
			if (RREADY_IN) begin
				RVALID_OUT <= 1'b0;
				ARREADY_OUT <= 1'b1;
			end
		end else if (ARVALID_IN && ARREADY_OUT) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT <= 1'b1;
			RRESP_OUT <= decode_ok(ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
			RDATA_OUT <= '0;
			if (ARADDR_IN == byte_addr(IDX_OUTPUT_DATA)) begin
				RDATA_OUT <= {25'h0000000, port_output_data};
			end
			if (ARADDR_IN == byte_addr(IDX_PIN_LEVELS)) begin
				RDATA_OUT <= {25'h0000000, port_pin_levels};
			end
			if (ARADDR_IN == byte_addr(IDX_DIRECTION)) begin
				RDATA_OUT <= {25'h0000000, port_direction};
			end
			if (ARADDR_IN == byte_addr(IDX_PULLUP_ENABLE)) begin
				RDATA_OUT <= {25'h0000000, port_pullup_enable};
			end
			if (ARADDR_IN == byte_addr(IDX_OUTPUT_FUNCTION_SELECT)) begin
				RDATA_OUT <= {24'h000000, port_output_function_select};
			end
			if (ARADDR_IN == byte_addr(IDX_NOISE_FILTER_CONTROL)) begin
				RDATA_OUT <= {24'h000000, noise_filter_control};
			end
		end else begin
			ARREADY_OUT <= 1'b1;
		end
	end

	chk_input_pin_mode: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		!port_direction[6] |=> !PIN_OE_OUT[6])
		else $error("input-mode pin is driven");
	chk_port_data_drive: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		port_direction[5] |=> PIN_OE_OUT[5] && PIN_OUT[5] == $past(port_output_data[5]))
		else $error("output pin not driven from data");
	chk_timer_select: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		port_direction[0] && port_output_function_select[0] &&
		!port_output_function_select[4] |=> PIN_OUT[0] == $past(TIMER_ZERO_OUTPUT_IN))
		else $error("pin 0 not carrying timer output");
	chk_pullup_follow: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		##1 PULLUP_EN_OUT == $past(port_pullup_enable))
		else $error("pull-up output lags its register");
	chk_large_current: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		port_direction[3] && port_output_function_select[7]
		|=> LARGE_CURRENT_OUT[3] && !PIN_OUT[3])
		else $error("large current drive not open N-channel");
	chk_ext_interrupt: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		##1 EXT_INTERRUPT_OUT == $past(pin_sync[6:4]))
		else $error("interrupt feed does not follow pins");
	chk_zero_cross_read: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		ARVALID_IN && ARREADY_OUT && !RVALID_OUT &&
		ARADDR_IN == byte_addr(IDX_PIN_LEVELS) && noise_filter_control[3]
		|=> RDATA_OUT[4] == $past(zc_sync[0]))
		else $error("zero-cross 0 not on input bit 4");
	chk_write_response: assert property (
		@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
		wr_fire |=> BVALID_OUT && $stable(port_direction) ||
		$past(aw_addr) != byte_addr(IDX_PIN_LEVELS))
		else $error("input register write disturbed state");
	cov_timer_pin: cover property (@(posedge REF_CLK_IN)
		port_direction[1] && port_output_function_select[1]);
	cov_led_drive: cover property (@(posedge REF_CLK_IN)
		LARGE_CURRENT_OUT != '0);
	cov_read_done: cover property (@(posedge REF_CLK_IN)
		RVALID_OUT && RREADY_IN);
endmodule // port5_gpio

// File: sim/pin_board.sv
`timescale 1ns/1ns
module pin_board (
	// clock
	input wire logic clk_in,
	// device side
	input wire logic [6:0] pin_drive_in,
	input wire logic [6:0] pin_oe_in,
	input wire logic [6:0] pullup_en_in,
	// external source
	input wire logic [6:0] ext_val_in,
	input wire logic [6:0] ext_en_in,
	// resolved levels
	output logic [6:0] level_out
);
	logic flt = 1'b0;
	// floating pin toggles so no steady value is guessed
	always @(posedge clk_in) flt <= ~flt;
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (pin_oe_in[i]) level_out[i] = pin_drive_in[i];
			else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
			else if (pullup_en_in[i]) level_out[i] = 1'b1;
			else level_out[i] = flt;
		end
	end
endmodule // pin_board

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top import port5_pkg::*;;
	logic clk = 0, rst_n = 0;
	always #5 clk = ~clk;
	logic [19:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 0, rdata, seed = 32'h8516D290;
	logic [3:0] wstrb = 4'hF, tmr = 0, lc;
	logic [1:0] zc = 0, bresp, rresp;
	logic [6:0] ext_val = 0, ext_en = 0, lvl, p_out, p_oe, pu;
	logic [2:0] eint;
	logic [7:0] nfc;
	int n_fail = 0, checks = 0;
	port5_gpio i_port5_gpio (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
		.AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
		.WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
		.WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
		.BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
		.ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
		.RVALID_OUT(rvalid), .RREADY_IN(rready), .PIN_IN(lvl),
		.PIN_OUT(p_out), .PIN_OE_OUT(p_oe), .PULLUP_EN_OUT(pu),
		.LARGE_CURRENT_OUT(lc), .TIMER_ZERO_OUTPUT_IN(tmr[0]),
		.TIMER_SEVEN_OUTPUT_IN(tmr[1]), .TIMER_TWO_OUTPUT_IN(tmr[2]),
		.TIMER_EIGHT_OUTPUT_IN(tmr[3]), .ZERO_CROSS0_IN(zc[0]),
		.ZERO_CROSS1_IN(zc[1]), .EXT_INTERRUPT_OUT(eint),
		.NOISE_FILTER_CONTROL_OUT(nfc));
	pin_board i_pin_board (.clk_in(clk), .pin_drive_in(p_out),
		.pin_oe_in(p_oe), .pullup_en_in(pu), .ext_val_in(ext_val),
		.ext_en_in(ext_en), .level_out(lvl));

	function logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
		return seed;
	endfunction
	// expected {oe, out}; large current sinks for 0, releases for 1
	function automatic logic [13:0] pin_exp(input logic [6:0] dr, dt,
		input logic [7:0] f, input logic [3:0] t);
		logic [6:0] oe, o;
		logic s, led;
		for (int i = 0; i < 7; i++) begin
			led = i < 4 && f[4 + i % 4];
			s = (i < 4 && f[i % 4]) ? t[i % 4] : dt[i];
			oe[i] = dr[i] && !(led && s);
			o[i] = led ? 1'b0 : s;
		end
		return {oe, o};
	endfunction
	task final_report;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask
	task tmo(input string nm);
		$display("mismatch %s exp answer got none", nm);
		n_fail++;
		final_report;
	endtask
	task wr(input logic [19:0] idx, input logic [31:0] d);
		int n;
		awaddr <= {idx[17:0], 2'h0};
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid && bready) break;
		end
		if (n == 50) tmo("write");
		bready <= 0;
		chk("bresp", (idx[7:0] == 8'h00) ? RESP_SLVERR : RESP_OKAY, bresp);
		// idle edge keeps back-to-back handshakes apart
		@(posedge clk);
	endtask
	task rd(input logic [19:0] idx, output logic [31:0] d);
		int n;
		araddr <= {idx[17:0], 2'h0};
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid && rready) break;
		end
		if (n == 50) tmo("read");
		d = rdata;
		rready <= 0;
		chk("rresp", (idx[7:0] == 8'h00) ? RESP_SLVERR : RESP_OKAY, rresp);
		@(posedge clk);
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		tmo("run");
	end
	initial begin
		logic [19:0] regs [4];
		logic [31:0] d, m;
		logic [6:0] dir, dat, pl;
		logic [7:0] fs;
		logic [13:0] e;
		regs = '{IDX_OUTPUT_DATA, IDX_DIRECTION, IDX_PULLUP_ENABLE,
			IDX_OUTPUT_FUNCTION_SELECT};
		repeat (20) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		chk("oe_reset", 32'h0, p_oe);
		for (int k = 0; k < 4; k++) begin
			rd(regs[k], d);
			if (k > 0) chk("reg_reset", 32'h0, d);
			m = (k < 3) ? 32'h7F : 32'hFF;
			wr(regs[k], 32'hFFFFFF80 | rnd());
			rd(regs[k], d);
			chk("readback", (32'hFFFFFF80 | seed) & m, d);
		end
		for (int k = 0; k < 12; k++) begin
			{dir, dat, fs} = 22'(rnd());
			if (k == 0) {dir, fs} = 15'h7FFF;
			wr(IDX_DIRECTION, dir);
			wr(IDX_OUTPUT_DATA, dat);
			wr(IDX_OUTPUT_FUNCTION_SELECT, fs);
			tmr <= 4'(rnd());
			repeat (2) @(posedge clk);
			e = pin_exp(dir, dat, fs, tmr);
			chk("pin_oe", e[13:7], p_oe);
			chk("pin_out", e[6:0] & e[13:7], p_out & e[13:7]);
			chk("large_cur", fs[7:4] & dir[3:0], lc);
		end
		wr(IDX_DIRECTION, 0);
		for (int k = 0; k < 6; k++) begin
			{pl, d[13:0]} = 21'(rnd());
			if (k == 0) {pl, d[13:7]} = 14'h3F80;
			// pin stimulus by nba so the synchroniser sees no race
			ext_en <= d[13:7];
			ext_val <= d[6:0];
			wr(IDX_PULLUP_ENABLE, pl);
			repeat (4) @(posedge clk);
			rd(IDX_PIN_LEVELS, d);
			m = ext_en | pl;
			chk("levels", (ext_en & ext_val | ~ext_en & pl) & m, d & m);
			chk("pullup", pl, pu);
			chk("ext_int", lvl[6:4] & m[6:4], eint & m[6:4]);
		end
		wr(IDX_NOISE_FILTER_CONTROL, 32'h88);
		chk("nf_copy", 32'h88, nfc);
		for (int k = 0; k < 4; k++) begin
			zc <= k[1:0];
			repeat (4) @(posedge clk);
			rd(IDX_PIN_LEVELS, d);
			chk("zero_cross", k[1:0], d[5:4]);
		end
		wr(IDX_PIN_LEVELS, 32'h7F);
		rd(IDX_DIRECTION, d);
		chk("dir_after_ro", 32'h0, d);
		chk("oe_after_ro", 32'h0, p_oe);
		wr(20'h03F00, 32'h7F);
		rd(20'h03F00, d);
		chk("unmapped", 32'h0, d);
		final_report;
	end
endmodule // tb_top
